// file: core/bmx_core.sv
// Execution core for bit moves, pointer load, code-byte loads, external moves,
// multiply, no-operation and byte OR. Instructions arrive decoded as opcode plus
// operand bytes; memory-side values (bit, direct byte, register) are supplied by
// the surrounding core, synchronous to clk.
`timescale 1ns/1ps

// Functional notes
// - Bit moves copy one bit between carry and an addressed bit only.
// - Opcode A3: two bytes, one cycle, carry takes addressed bit.
// - Opcode 92: two bytes, two cycles, addressed bit takes carry.
// - Pointer load: byte two to high, byte three to low, flags kept.
// - Code address is accumulator plus 16-bit base; result to accumulator.
// - Opcode 83: advance program counter first, then add accumulator.
// - Data pointer is left unchanged by a code-byte load.
// - Indirect external moves put the 8-bit register on the low port.
// - Pointer external moves drive high byte on high port, low multiplexed.
// - High port latch keeps its value and returns after the transfer.
// - Opcode A4, four cycles: low product to accumulator, high to B.
// - Multiply sets overflow when product exceeds FF, always clears carry.
// - Opcode 00: one byte, one cycle, only program counter advances.
// - OR into accumulator from register, direct or indirect, flags untouched.
// - Six OR forms: four to accumulator, two to a direct byte.
// - OR on a port reads the output latch, not the pins.
module bmx_core
    import bmx_pkg::*;
(
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    input wire logic ce,
    // Instruction issue
    input wire logic issue,
    input wire logic [7:0] opcode,
    input wire logic [7:0] operand1,
    input wire logic [7:0] operand2,
    output logic busy,
    output logic done,
    // Operand sources from the rest of the core
    input wire logic bit_value,
    input wire logic [7:0] direct_value,
    input wire logic direct_is_port,
    input wire logic [7:0] port_latch_value,
    input wire logic [7:0] bank_working_register,
    input wire logic [7:0] indirect_pointer_register,
    input wire logic [7:0] indirect_value,
    // Program memory read port
    output logic [15:0] code_addr,
    output logic code_rd,
    input wire logic [7:0] code_data,
    // Direct byte and bit write-back
    output logic bit_we,
    output logic bit_wdata,
    output logic direct_we,
    output logic [7:0] direct_wdata,
    // Architectural state
    output logic [7:0] acc_ff,
    output logic [7:0] b_ff,
    output logic carry_ff,
    output logic overflow_flag_ff,
    output logic [7:0] data_pointer_high_ff,
    output logic [7:0] data_pointer_low_ff,
    output logic [15:0] pc_ff,
    // High port latch write
    input wire logic high_latch_we,
    input wire logic [7:0] high_latch_wdata,
    output logic [7:0] high_latch_ff,
    // Auxiliary register load from the rest of the core
    input wire logic b_we,
    input wire logic [7:0] b_wdata,
    // External bus pins
    output logic [7:0] low_muxed_port_o,
    output logic low_muxed_port_oe,
    input wire logic [7:0] low_muxed_port_i,
    output logic [7:0] high_address_port_o,
    output logic ale,
    output logic rd_n,
    output logic wr_n
);
    bmx_state_t state_ff;
    bmx_state_t nxt_state;
    logic [7:0] op_ff;
    logic [7:0] opnd1_ff;
    logic [7:0] opnd2_ff;
    logic [2:0] cyc_ff;
    logic [2:0] need_cyc;
    logic is_xmove;
    logic is_xwrite;
    logic use_dp;
    logic [7:0] mul_lo;
    logic [7:0] mul_hi;
    logic mul_ovf;
    logic [7:0] or_src;
    logic [7:0] dir_base;
    logic [15:0] pc_next;
    logic [15:0] code_base;
    logic [7:0] xaddr_hi_ff;
    logic [7:0] xaddr_lo_ff;
    logic [7:0] xwdata_ff;
    logic xwr_ff;
    logic xdp_ff;
    logic finish;

    bmx_mul u_mul (
        .a_in(acc_ff),
        .b_in(b_ff),
        .prod_lo(mul_lo),
        .prod_hi(mul_hi),
        .ovf(mul_ovf)
    );

    // Decode of the captured opcode.
    assign use_dp = (op_ff == OP_XRD_DP) || (op_ff == OP_XWR_DP);
    assign is_xmove = use_dp || (op_ff[7:1] == OP_XRD_RI) || (op_ff[7:1] == OP_XWR_RI);
    assign is_xwrite = (op_ff == OP_XWR_DP) || (op_ff[7:1] == OP_XWR_RI);

    // Cycle budget per instruction; external moves are sequenced by their own states.
    always_comb begin
        need_cyc = CYC_ONE;
        if (op_ff == OP_MUL) begin
            need_cyc = CYC_FOUR;
        end else if (op_ff == OP_BIT_FROM_C || op_ff == OP_DP_LOAD
                     || op_ff == OP_CODE_DP || op_ff == OP_CODE_PC
                     || op_ff == OP_OR_DIR_IMM) begin
            need_cyc = CYC_TWO;
        end
    end

    // Program counter after this instruction: one, two or three bytes.
    always_comb begin
        pc_next = pc_ff + LEN_ONE;
        if (op_ff == OP_DP_LOAD || op_ff == OP_OR_DIR_IMM) begin
            pc_next = pc_ff + LEN_THREE;
        end else if (op_ff == OP_C_FROM_BIT || op_ff == OP_BIT_FROM_C
                     || op_ff == OP_OR_DIR || op_ff == OP_OR_IMM
                     || op_ff == OP_OR_DIR_A) begin
            pc_next = pc_ff + LEN_TWO;
        end
    end

    // The counter-relative form adds to the already advanced counter.
    assign code_base = (op_ff == OP_CODE_PC) ? pc_next :
                       {data_pointer_high_ff, data_pointer_low_ff};
    assign code_addr = code_base + {ZERO8, acc_ff};
    assign code_rd = (state_ff == BMX_EXEC)
                     && (op_ff == OP_CODE_DP || op_ff == OP_CODE_PC);

    // OR sources: a port destination is read from its latch so a pin held low
    // by the outside world cannot clear bits that software had set.
    assign dir_base = direct_is_port ? port_latch_value : direct_value;
    always_comb begin
        or_src = operand_imm(op_ff);
        if (op_ff[7:3] == OP_OR_REG) begin
            or_src = bank_working_register;
        end else if (op_ff == OP_OR_DIR) begin
            or_src = dir_base;
        end else if (op_ff[7:1] == OP_OR_IND) begin
            or_src = indirect_value;
        end
    end

    function automatic logic [7:0] operand_imm(input logic [7:0] op);
        operand_imm = opnd1_ff;
    endfunction

    // External moves end in their data state, so they must not finish here as
    // well, or done would pulse twice and the counter would step twice.
    assign finish = ce && (state_ff == BMX_EXEC) && !is_xmove && (cyc_ff == need_cyc);

    always_comb begin
        nxt_state = state_ff;
        unique case (state_ff)
            BMX_IDLE: begin
                if (issue) begin
                    nxt_state = BMX_EXEC;
                end
            end
            BMX_EXEC: begin
                if (is_xmove) begin
                    nxt_state = BMX_XADR;
                end else if (finish) begin
                    nxt_state = BMX_IDLE;
                end
            end
            BMX_XADR: begin
                nxt_state = BMX_XDAT;
            end
            BMX_XDAT: begin
                nxt_state = BMX_IDLE;
            end
            default: begin
                nxt_state = BMX_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            state_ff <= BMX_IDLE;
        end else if (ce) begin
            state_ff <= nxt_state;
        end
    end

    // Instruction capture and cycle counter.
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            op_ff <= OP_NOP;
            opnd1_ff <= ZERO8;
            opnd2_ff <= ZERO8;
            cyc_ff <= CYC_ONE;
        end else if (ce) begin
            if (state_ff == BMX_IDLE && issue) begin
                op_ff <= opcode;
                opnd1_ff <= operand1;
                opnd2_ff <= operand2;
                cyc_ff <= CYC_ONE;
            end else if (state_ff == BMX_EXEC && !finish) begin
                cyc_ff <= cyc_ff + CYC_ONE;
            end
        end
    end

    assign busy = (state_ff != BMX_IDLE);
    assign done = finish || (ce && state_ff == BMX_XDAT);

    // Accumulator and B.
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            acc_ff <= ZERO8;
            b_ff <= ZERO8;
        end else if (ce) begin
            if (finish) begin
                if (op_ff == OP_MUL) begin
                    acc_ff <= mul_lo;
                    b_ff <= mul_hi;
                end else if (op_ff == OP_CODE_DP || op_ff == OP_CODE_PC) begin
                    acc_ff <= code_data;
                end else if (op_ff[7:3] == OP_OR_REG || op_ff == OP_OR_DIR
                             || op_ff[7:1] == OP_OR_IND || op_ff == OP_OR_IMM) begin
                    acc_ff <= acc_ff | or_src;
                end
            end else if (state_ff == BMX_XDAT && !xwr_ff) begin
                acc_ff <= low_muxed_port_i;
            end
            // A product landing in the same cycle wins over a load from outside.
            if (b_we && !(finish && op_ff == OP_MUL)) begin
                b_ff <= b_wdata;
            end
        end
    end

    // Flags: only the carry-from-bit move and multiply touch them.
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            carry_ff <= 1'b0;
            overflow_flag_ff <= 1'b0;
        end else if (ce && finish) begin
            if (op_ff == OP_C_FROM_BIT) begin
                carry_ff <= bit_value;
            end else if (op_ff == OP_MUL) begin
                carry_ff <= 1'b0;
                overflow_flag_ff <= mul_ovf;
            end
        end
    end

    // Data pointer changes only on its immediate load; code loads leave it alone.
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            data_pointer_high_ff <= ZERO8;
            data_pointer_low_ff <= ZERO8;
        end else if (ce && finish && op_ff == OP_DP_LOAD) begin
            data_pointer_high_ff <= opnd1_ff;
            data_pointer_low_ff <= opnd2_ff;
        end
    end

    // Program counter.
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            pc_ff <= ZERO16;
        end else if (ce && (finish || state_ff == BMX_XDAT)) begin
            pc_ff <= pc_next;
        end
    end

    // Bit and direct byte write-back pulses.
    assign bit_we = finish && (op_ff == OP_BIT_FROM_C);
    assign bit_wdata = carry_ff;
    assign direct_we = finish && (op_ff == OP_OR_DIR_A || op_ff == OP_OR_DIR_IMM);
    assign direct_wdata = dir_base | ((op_ff == OP_OR_DIR_A) ? acc_ff : opnd2_ff);

    // External transfer address and data capture.
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            xaddr_hi_ff <= ZERO8;
            xaddr_lo_ff <= ZERO8;
            xwdata_ff <= ZERO8;
            xwr_ff <= 1'b0;
            xdp_ff <= 1'b0;
        end else if (ce && state_ff == BMX_EXEC && is_xmove) begin
            xaddr_hi_ff <= data_pointer_high_ff;
            xaddr_lo_ff <= use_dp ? data_pointer_low_ff : indirect_pointer_register;
            xwdata_ff <= acc_ff;
            xwr_ff <= is_xwrite;
            xdp_ff <= use_dp;
        end
    end

    // The high port latch is never overwritten by a transfer, so the pins fall
    // back to it on their own once the data phase ends.
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            high_latch_ff <= BYTE_MAX;
        end else if (ce && high_latch_we) begin
            high_latch_ff <= high_latch_wdata;
        end
    end

    assign high_address_port_o = (busy && state_ff != BMX_EXEC && xdp_ff) ?
                                 xaddr_hi_ff : high_latch_ff;
    assign ale = (state_ff == BMX_XADR);
    assign rd_n = !(state_ff == BMX_XDAT && !xwr_ff);
    assign wr_n = !(state_ff == BMX_XDAT && xwr_ff);
    assign low_muxed_port_o = (state_ff == BMX_XADR) ? xaddr_lo_ff : xwdata_ff;
    assign low_muxed_port_oe = (state_ff == BMX_XADR) || (state_ff == BMX_XDAT && xwr_ff);
endmodule

// file: core/bmx_pkg.sv
// Package for the bit-move, external-move, multiply and OR execution block.
// Assumes a single 200 MHz core clock; all codes and counts used by the core live here.
package bmx_pkg;
    localparam logic [7:0] OP_C_FROM_BIT = 8'hA3;
    localparam logic [7:0] OP_BIT_FROM_C = 8'h92;
    localparam logic [7:0] OP_DP_LOAD = 8'h90;
    localparam logic [7:0] OP_CODE_DP = 8'h93;
    localparam logic [7:0] OP_CODE_PC = 8'h83;
    localparam logic [7:0] OP_XRD_DP = 8'hE0;
    localparam logic [7:0] OP_XWR_DP = 8'hF0;
    localparam logic [6:0] OP_XRD_RI = 7'h71;
    localparam logic [6:0] OP_XWR_RI = 7'h79;
    localparam logic [7:0] OP_MUL = 8'hA4;
    localparam logic [7:0] OP_NOP = 8'h00;
    localparam logic [4:0] OP_OR_REG = 5'h09;
    localparam logic [7:0] OP_OR_DIR = 8'h45;
    localparam logic [6:0] OP_OR_IND = 7'h23;
    localparam logic [7:0] OP_OR_IMM = 8'h44;
    localparam logic [7:0] OP_OR_DIR_A = 8'h42;
    localparam logic [7:0] OP_OR_DIR_IMM = 8'h43;
    localparam logic [7:0] BYTE_MAX = 8'hFF;
    localparam logic [7:0] ZERO8 = 8'h00;
    localparam logic [15:0] ZERO16 = 16'h0000;
    localparam logic [2:0] CYC_ONE = 3'h1;
    localparam logic [2:0] CYC_TWO = 3'h2;
    localparam logic [2:0] CYC_FOUR = 3'h4;
    localparam logic [15:0] LEN_ONE = 16'h0001;
    localparam logic [15:0] LEN_TWO = 16'h0002;
    localparam logic [15:0] LEN_THREE = 16'h0003;
    typedef enum logic [3:0] {
        BMX_IDLE = 4'h1,
        BMX_EXEC = 4'h2,
        BMX_XADR = 4'h4,
        BMX_XDAT = 4'h8
    } bmx_state_t;
endpackage

// file: core/bmx_mul.sv
// Unsigned 8x8 multiplier with overflow detection.
// Purely combinational; the caller registers the results.
`timescale 1ns/1ps
module bmx_mul
    import bmx_pkg::*;
(
    // Operands
    input wire logic [7:0] a_in,
    input wire logic [7:0] b_in,
    // Results
    output logic [7:0] prod_lo,
    output logic [7:0] prod_hi,
    output logic ovf
);
    logic [15:0] prod;
    assign prod = 16'(a_in) * 16'(b_in);
    assign prod_lo = prod[7:0];
    assign prod_hi = prod[15:8];
    assign ovf = (prod_hi != ZERO8);
endmodule

// file: verification/bmx_core_asserts.sv
// Checker of the execution core: instruction timing, results and bus pins.
// Bound into every core; assumes ce high and no latch write while busy.
`timescale 1ns/1ps
module bmx_core_chk
    import bmx_pkg::*;
(
    // Clock, reset and issue
    input wire logic clk,
    input wire logic rst,
    input wire logic issue,
    input wire logic [7:0] opcode,
    input wire logic [7:0] operand1,
    input wire logic [7:0] operand2,
    input wire logic busy,
    input wire logic done,
    // Operands and bit write-back
    input wire logic bit_value,
    input wire logic [7:0] indirect_pointer_register,
    input wire logic bit_we,
    input wire logic bit_wdata,
    input wire logic code_rd,
    // Architectural state
    input wire logic [7:0] acc_ff,
    input wire logic [7:0] b_ff,
    input wire logic carry_ff,
    input wire logic overflow_flag_ff,
    input wire logic [7:0] data_pointer_high_ff,
    input wire logic [7:0] data_pointer_low_ff,
    input wire logic [7:0] high_latch_ff,
    // Bus pins
    input wire logic [7:0] low_muxed_port_o,
    input wire logic low_muxed_port_oe,
    input wire logic [7:0] high_address_port_o,
    input wire logic ale,
    input wire logic rd_n,
    input wire logic wr_n
);
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    sequence s_go(logic [7:0] op);
        !busy && issue && opcode == op;
    endsequence
    sequence s_addr(logic [7:0] lo, logic [7:0] hi);
        ale && low_muxed_port_oe && low_muxed_port_o == lo && high_address_port_o == hi;
    endsequence
    property p_c_from_bit;
        s_go(OP_C_FROM_BIT) |=> done ##1 carry_ff == $past(bit_value);
    endproperty
    a_c_from_bit: assert property (p_c_from_bit) else $error("carry load wrong");
    property p_bit_from_c;
        s_go(OP_BIT_FROM_C) |=> !bit_we ##1 done && bit_we && bit_wdata == carry_ff;
    endproperty
    a_bit_from_c: assert property (p_bit_from_c) else $error("bit store wrong");
    property p_dp_load;
        s_go(OP_DP_LOAD) ##1 !done ##1 done |=> data_pointer_high_ff == $past(operand1, 3)
            && data_pointer_low_ff == $past(operand2, 3);
    endproperty
    a_dp_load: assert property (p_dp_load) else $error("pointer load wrong");
    property p_mul;
        s_go(OP_MUL) |=> !done [*3] ##1 done ##1
            {b_ff, acc_ff} == 16'($past(acc_ff, 5)) * 16'($past(b_ff, 5));
    endproperty
    a_mul: assert property (p_mul) else $error("product wrong");
    property p_mul_flags;
        s_go(OP_MUL) ##4 done |=> !carry_ff && overflow_flag_ff == (b_ff != ZERO8);
    endproperty
    a_mul_flags: assert property (p_mul_flags) else $error("multiply flags wrong");
    property p_xrd_dp;
        s_go(OP_XRD_DP) |=> !ale ##1 s_addr(data_pointer_low_ff, data_pointer_high_ff)
            ##1 done && !rd_n && wr_n && high_address_port_o == data_pointer_high_ff;
    endproperty
    a_xrd_dp: assert property (p_xrd_dp) else $error("pointer read bus wrong");
    property p_xwr_ri;
        !busy && issue && opcode[7:1] == OP_XWR_RI |=> ##1 s_addr(indirect_pointer_register,
            high_latch_ff) ##1 done && !wr_n && low_muxed_port_oe && low_muxed_port_o == acc_ff;
    endproperty
    a_xwr_ri: assert property (p_xwr_ri) else $error("indirect write bus wrong");
    property p_latch_out;
        !busy |-> high_address_port_o == high_latch_ff;
    endproperty
    a_latch_out: assert property (p_latch_out) else $error("high port not latch");
    property p_latch_keep;
        busy |=> $stable(high_latch_ff);
    endproperty
    a_latch_keep: assert property (p_latch_keep) else $error("latch changed");
    property p_code_dp;
        s_go(OP_CODE_DP) |=> code_rd [*2] ##1 !code_rd;
    endproperty
    a_code_dp: assert property (p_code_dp) else $error("code read strobe wrong");
endmodule
bind bmx_core bmx_core_chk bmx_core_chk_i (.*);

// file: verification/bmx_xmem.sv
// External data memory on the multiplexed bus, used by the core's bench.
// Sees the resolved low port; the bench merges both drivers onto it.
`timescale 1ns/1ps
module bmx_xmem (
    // Clock and strobes
    input wire logic clk,
    input wire logic ale,
    input wire logic rd_n,
    input wire logic wr_n,
    // Address and data
    input wire logic [7:0] bus_lo,
    input wire logic [7:0] bus_hi,
    output logic [7:0] rd_data
);
    logic [7:0] mem [0:65535];
    logic [15:0] addr_ff = 16'h0000;
    logic [7:0] last_ff = 8'h00;
    always_ff @(posedge clk) begin
        if (ale) addr_ff <= {bus_hi, bus_lo};
        if (!wr_n) mem[addr_ff] <= bus_lo;
        if (!rd_n) last_ff <= rd_data;
    end
    // A released bus shows the inverse of the last byte, so a late sample cannot pass.
    assign rd_data = !rd_n ? mem[addr_ff] : ~last_ff;
endmodule

// file: verification/test_bit_move_ext_mem_mul_or_exec.sv
// Self-checking bench of the execution core with an external data memory model.
// Inputs change 1 ns after the rising edge; ce stays high for the whole run.
`timescale 1ns/1ps
`define CHK(name, exp, got) begin checks_done++; if ((got) !== (exp)) begin miscompares++; \
    $display("wrong value %s expected %h seen %h", name, exp, got); end end
module test_bit_move_ext_mem_mul_or_exec
    import bmx_pkg::*;
;
    logic clk = 1'b0, rst = 1'b1, ce = 1'b1, issue = 1'b0, bit_value = 1'b0;
    logic direct_is_port = 1'b0, high_latch_we = 1'b0, b_we = 1'b0;
    logic [7:0] opcode = 8'h00, operand1 = 8'h00, operand2 = 8'h00, direct_value = 8'h00;
    logic [7:0] port_latch_value = 8'h00, bank_working_register = 8'h00, indirect_value = 8'h00;
    logic [7:0] indirect_pointer_register = 8'h00, high_latch_wdata = 8'h00, b_wdata = 8'h00;
    logic busy, done, code_rd, bit_we, bit_wdata, direct_we, carry_ff, overflow_flag_ff;
    logic ale, rd_n, wr_n, low_muxed_port_oe, wen;
    logic [7:0] direct_wdata, acc_ff, b_ff, data_pointer_high_ff, data_pointer_low_ff;
    logic [7:0] high_latch_ff, low_muxed_port_o, low_muxed_port_i, high_address_port_o;
    logic [7:0] rd_data, code_data, wdat, a0;
    logic [15:0] code_addr, pc_ff, pc0;
    int miscompares = 0, checks_done = 0, cyc = 0;
    bmx_core bmx_core_i (.*);
    bmx_xmem bmx_xmem_i (.clk(clk), .ale(ale), .rd_n(rd_n), .wr_n(wr_n),
        .bus_lo(low_muxed_port_i), .bus_hi(high_address_port_o), .rd_data(rd_data));
    assign low_muxed_port_i = low_muxed_port_oe ? low_muxed_port_o : rd_data;
    // Each code location returns a byte derived from its address, so a wrong fetch shows.
    assign code_data = code_addr[7:0] ^ 8'h5A;
    always #2.5 clk = ~clk;
    task stop_test;
        $display("checks %0d miscompares %0d", checks_done, miscompares);
        if (miscompares == 0 && checks_done > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask
    task load_b(input logic [7:0] v);
        b_wdata = v;
        b_we = 1'b1;
        @(posedge clk);
        #1;
        b_we = 1'b0;
    endtask
    task run(input logic [7:0] op, input logic [7:0] o1, input logic [7:0] o2);
        issue = 1'b1;
        opcode = op;
        operand1 = o1;
        operand2 = o2;
        @(posedge clk);
        #1;
        issue = 1'b0;
        cyc = 1;
        while (done !== 1'b1) begin
            if (cyc > 8) begin
                miscompares++;
                stop_test;
            end
            @(posedge clk);
            #1;
            cyc++;
        end
        wdat = direct_wdata;
        wen = direct_we;
        @(posedge clk);
        #1;
    endtask
    task t_bits_ptr;
        bit_value = 1'b1;
        run(OP_C_FROM_BIT, 8'h20, 8'h00);
        `CHK("carry", 1'b1, carry_ff)
        `CHK("cycles", 1, cyc)
        run(OP_BIT_FROM_C, 8'h21, 8'h00);
        `CHK("cycles", 2, cyc)
        run(OP_DP_LOAD, 8'h12, 8'h34);
        `CHK("pointer", 16'h1234, {data_pointer_high_ff, data_pointer_low_ff})
        `CHK("carry", 1'b1, carry_ff)
        bit_value = 1'b0;
        run(OP_C_FROM_BIT, 8'h22, 8'h00);
        `CHK("carry", 1'b0, carry_ff)
        `CHK("acc", 8'h00, acc_ff)
        bit_value = 1'b1;
        run(OP_C_FROM_BIT, 8'h22, 8'h00);
        run(OP_MUL, 8'h00, 8'h00);
        `CHK("cycles", 4, cyc)
        `CHK("product", 16'h0000, {b_ff, acc_ff})
        `CHK("flags", 2'b00, {carry_ff, overflow_flag_ff})
        run(OP_OR_IMM, 8'h50, 8'h00);
        run(OP_C_FROM_BIT, 8'h22, 8'h00);
        load_b(8'hA0);
        run(OP_MUL, 8'h00, 8'h00);
        `CHK("product", 16'h3200, {b_ff, acc_ff})
        `CHK("flags", 2'b01, {carry_ff, overflow_flag_ff})
        load_b(8'h00);
        $display("test bits_ptr done");
    endtask
    task t_ext;
        run(OP_OR_IMM, 8'hA5, 8'h00);
        run(OP_XWR_DP, 8'h00, 8'h00);
        `CHK("cycles", 3, cyc)
        run(OP_MUL, 8'h00, 8'h00);
        run(OP_XRD_DP, 8'h00, 8'h00);
        `CHK("acc", 8'hA5, acc_ff)
        `CHK("latch", 8'hFF, high_latch_ff)
        high_latch_wdata = 8'h12;
        high_latch_we = 1'b1;
        @(posedge clk);
        #1;
        high_latch_we = 1'b0;
        indirect_pointer_register = 8'h56;
        run({OP_XWR_RI, 1'b1}, 8'h00, 8'h00);
        `CHK("cycles", 3, cyc)
        run(OP_MUL, 8'h00, 8'h00);
        run({OP_XRD_RI, 1'b0}, 8'h00, 8'h00);
        `CHK("acc", 8'hA5, acc_ff)
        `CHK("latch", 8'h12, high_latch_ff)
        $display("test ext done");
    endtask
    task t_or;
        run(OP_MUL, 8'h00, 8'h00);
        run(OP_OR_IMM, 8'hC3, 8'h00);
        bank_working_register = 8'h55;
        run({OP_OR_REG, 3'h2}, 8'h00, 8'h00);
        `CHK("acc", 8'hD7, acc_ff)
        `CHK("cycles", 1, cyc)
        direct_value = 8'h08;
        run(OP_OR_DIR, 8'h30, 8'h00);
        `CHK("acc", 8'hDF, acc_ff)
        indirect_value = 8'h20;
        run(OP_C_FROM_BIT, 8'h22, 8'h00);
        run({OP_OR_IND, 1'b1}, 8'h00, 8'h00);
        `CHK("acc", 8'hFF, acc_ff)
        `CHK("carry", 1'b1, carry_ff)
        run(OP_MUL, 8'h00, 8'h00);
        direct_is_port = 1'b1;
        port_latch_value = 8'h01;
        direct_value = 8'hFF;
        run(OP_OR_DIR_A, 8'h90, 8'h00);
        `CHK("port write", 9'h101, {wen, wdat})
        run(OP_OR_DIR_IMM, 8'h90, 8'h32);
        `CHK("port write", 9'h133, {wen, wdat})
        `CHK("cycles", 2, cyc)
        $display("test or done");
    endtask
    task t_code;
        run(OP_OR_IMM, 8'hFF, 8'h00);
        run(OP_CODE_DP, 8'h00, 8'h00);
        `CHK("acc", 8'h69, acc_ff)
        `CHK("pointer", 16'h1234, {data_pointer_high_ff, data_pointer_low_ff})
        pc0 = pc_ff + 16'h006A;
        run(OP_CODE_PC, 8'h00, 8'h00);
        `CHK("acc", pc0[7:0] ^ 8'h5A, acc_ff)
        `CHK("cycles", 2, cyc)
        pc0 = pc_ff;
        a0 = acc_ff;
        run(OP_NOP, 8'h00, 8'h00);
        `CHK("pc", pc0 + 16'h0001, pc_ff)
        `CHK("acc", a0, acc_ff)
        `CHK("cycles", 1, cyc)
        $display("test code done");
    endtask
    initial begin
        repeat (10) @(posedge clk);
        #1;
        rst = 1'b0;
        t_bits_ptr;
        t_ext;
        t_or;
        t_code;
        stop_test;
    end
endmodule
